// ==== verilog/nv_byte_access.sv ====
// Register access and write timing for the nonvolatile byte store
`timescale 1ns/10ps
`include "nv_access_consts.svh"
// Notes on behaviour
// - Write strobe without read strobe stalls processor two cycles
// - Read strobe stalls processor four cycles
// - Nine-bit linear address, high bits zero
// - Data register feeds writes, receives reads
// - Control bits seven to three read zero
// - Write strobe only acts while armed
// - Arm bit clears after four cycles
// - Write strobe holds until write time ends
// - Read fetches byte, then strobe clears
// - Read completes inside its own stall
// - Address or data change aborts write
module nv_byte_access
  import nv_access_pkg::*;
#(
  parameter int WRITE_TIME_NS = `NV_WRITE_TIME_NS,
  parameter int WRITE_CYCLES = WRITE_TIME_NS / `NV_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic reset,
  input wire io_req_t io_req,
  input wire logic io_strobe,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic write_aborted
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [`NV_ADDR_BITS-1:0] nv_address_reg;
  logic [7:0] nv_data_reg;
  logic master_write_arm_reg;
  logic write_strobe_reg;
  logic read_strobe_reg;
  logic [2:0] arm_count_reg;
  logic [2:0] stall_count_reg;
  logic [31:0] write_count_reg;
  logic read_pending_reg;
  logic abort_reg;
  write_state_t state_reg;
  logic [7:0] cell_rdata;
  cell_req_t cell_req;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = io_strobe && io_req.we && (a == off);
  endfunction

  logic wr_ctrl;
  logic arm_set;
  logic write_start;
  logic read_start;
  logic addr_or_data_write;
  assign wr_ctrl = hit(io_req.addr, `NV_OFF_CONTROL);
  assign arm_set = wr_ctrl && io_req.wdata[`NV_BIT_ARM] && !io_req.wdata[`NV_BIT_WRITE];
  assign write_start = wr_ctrl && io_req.wdata[`NV_BIT_WRITE] && master_write_arm_reg
    && !write_strobe_reg;
  assign read_start = wr_ctrl && io_req.wdata[`NV_BIT_READ] && !read_strobe_reg;
  assign addr_or_data_write = hit(io_req.addr, `NV_OFF_ADDR_LOW)
    || hit(io_req.addr, `NV_OFF_ADDR_HIGH) || hit(io_req.addr, `NV_OFF_DATA);

  // ----------------------------------------
  // Address and data registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      nv_address_reg <= '0;
    end else if (hit(io_req.addr, `NV_OFF_ADDR_LOW)) begin
      nv_address_reg[7:0] <= io_req.wdata;
    end else if (hit(io_req.addr, `NV_OFF_ADDR_HIGH)) begin
      nv_address_reg[8] <= io_req.wdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nv_data_reg <= `NV_RESET_BYTE;
    end else if (hit(io_req.addr, `NV_OFF_DATA)) begin
      nv_data_reg <= io_req.wdata;
    end else if (read_pending_reg) begin
      nv_data_reg <= cell_rdata;
    end
  end

  // ----------------------------------------
  // Arm bit with timeout
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      master_write_arm_reg <= 1'b0;
      arm_count_reg <= 3'h0;
    end else if (arm_set) begin
      master_write_arm_reg <= 1'b1;
      arm_count_reg <= `NV_ARM_CYCLES;
    end else if (master_write_arm_reg) begin
      arm_count_reg <= arm_count_reg - 3'h1;
      if (arm_count_reg == 3'h1) begin
        master_write_arm_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Self-timed write
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      write_strobe_reg <= 1'b0;
      write_count_reg <= '0;
      abort_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (write_start) begin
            write_strobe_reg <= 1'b1;
            write_count_reg <= 32'(WRITE_CYCLES);
            abort_reg <= 1'b0;
            state_reg <= ST_WRITING;
          end
        end
        ST_WRITING: begin
          if (addr_or_data_write) begin
            abort_reg <= 1'b1;
          end
          if (write_count_reg <= 32'h1) begin
            state_reg <= ST_DONE;
          end else begin
            write_count_reg <= write_count_reg - 32'h1;
          end
        end
        ST_DONE: begin
          write_strobe_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Commit happens at the end of the write time unless aborted
  always_comb begin
    cell_req.we = (state_reg == ST_DONE) && !abort_reg;
    cell_req.addr = nv_address_reg;
    cell_req.wdata = nv_data_reg;
  end

  nv_cell_array #(.DEPTH(1 << `NV_ADDR_BITS)) u_cells (
    .clk(clk),
    .req(cell_req),
    .rdata(cell_rdata)
  );

  // ----------------------------------------
  // Read strobe
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      read_strobe_reg <= 1'b0;
      read_pending_reg <= 1'b0;
    end else if (read_start) begin
      read_strobe_reg <= 1'b1;
      read_pending_reg <= 1'b1;
    end else if (read_pending_reg) begin
      read_pending_reg <= 1'b0;
      read_strobe_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Processor stall
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      stall_count_reg <= 3'h0;
    end else if (read_start) begin
      stall_count_reg <= `NV_READ_STALL;
    end else if (write_start) begin
      stall_count_reg <= `NV_WRITE_STALL;
    end else if (stall_count_reg != 3'h0) begin
      stall_count_reg <= stall_count_reg - 3'h1;
    end
  end
  assign cpu_stall = (stall_count_reg != 3'h0);
  assign write_aborted = abort_reg;

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      io_rdata <= `NV_RESET_BYTE;
    end else if (io_req.addr == `NV_OFF_ADDR_LOW) begin
      io_rdata <= nv_address_reg[7:0];
    end else if (io_req.addr == `NV_OFF_ADDR_HIGH) begin
      io_rdata <= {7'h00, nv_address_reg[8]};
    end else if (io_req.addr == `NV_OFF_DATA) begin
      io_rdata <= nv_data_reg;
    end else if (io_req.addr == `NV_OFF_CONTROL) begin
      io_rdata <= {5'h00, master_write_arm_reg, write_strobe_reg, read_strobe_reg};
    end else begin
      io_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_write_stall;
    @(posedge clk) disable iff (reset) write_start && !read_start
      |=> cpu_stall [*2] ##1 !cpu_stall;
  endproperty
  a_write_stall: assert property (p_write_stall) else $error("write stall not two");

  property p_read_stall;
    @(posedge clk) disable iff (reset) read_start |=> cpu_stall [*4] ##1 !cpu_stall;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall not four");

  property p_high_zero;
    @(posedge clk) disable iff (reset) $past(io_req.addr) == `NV_OFF_ADDR_HIGH && !$past(reset)
      |-> io_rdata[7:1] == 7'h00;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("address high bits nonzero");

  property p_ctrl_zero;
    @(posedge clk) disable iff (reset) $past(io_req.addr) == `NV_OFF_CONTROL && !$past(reset)
      |-> io_rdata[7:3] == 5'h00;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control reserved bits nonzero");

  property p_unarmed;
    @(posedge clk) disable iff (reset) wr_ctrl && io_req.wdata[`NV_BIT_WRITE]
      && !master_write_arm_reg && !write_strobe_reg |=> !write_strobe_reg;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("write started unarmed");

  property p_arm_timeout;
    @(posedge clk) disable iff (reset) arm_set ##1 !arm_set [*4] |=> !master_write_arm_reg;
  endproperty
  a_arm_timeout: assert property (p_arm_timeout) else $error("arm bit did not time out");

  // Arm bit must stand for the full window, not expire early
  property p_arm_hold;
    @(posedge clk) disable iff (reset) arm_set |=> master_write_arm_reg [*4];
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("arm bit expired early");

  property p_strobe_hold;
    @(posedge clk) disable iff (reset) state_reg == ST_WRITING |-> write_strobe_reg;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("write strobe dropped early");

  property p_read_done;
    @(posedge clk) disable iff (reset) read_start |=> read_strobe_reg ##1 !read_strobe_reg;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read strobe not cleared");

  property p_abort;
    @(posedge clk) disable iff (reset) state_reg == ST_WRITING && addr_or_data_write |=> abort_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not recorded");
endmodule // nv_byte_access

// ==== inc/nv_access_consts.svh ====
// Offsets, field positions, reset values and timing counts of the byte access block
`ifndef NV_ACCESS_CONSTS_SVH
`define NV_ACCESS_CONSTS_SVH
`define NV_OFF_ADDR_HIGH 6'h1F
`define NV_OFF_ADDR_LOW 6'h1E
`define NV_OFF_DATA 6'h1D
`define NV_OFF_CONTROL 6'h1C
`define NV_BIT_READ 0
`define NV_BIT_WRITE 1
`define NV_BIT_ARM 2
`define NV_RESET_BYTE 8'h00
`define NV_WRITE_STALL 3'h2
`define NV_READ_STALL 3'h4
`define NV_ARM_CYCLES 3'h4
`define NV_WRITE_TIME_NS 2500000
`define NV_CLK_PERIOD_NS 20
`define NV_ADDR_BITS 9
`endif

// ==== inc/nv_access_pkg.sv ====
// Types shared by the byte access block
package nv_access_pkg;
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_t;
  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } cell_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITING = 2'b01,
    ST_DONE = 2'b11
  } write_state_t;
endpackage

// ==== verilog/nv_cell_array.sv ====
// Byte array that stands for the nonvolatile cells
`timescale 1ns/10ps
`include "nv_access_consts.svh"
module nv_cell_array
  import nv_access_pkg::*;
#(
  parameter int DEPTH = 512
) (
  input wire logic clk,
  input wire cell_req_t req,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[req.addr];
  end
endmodule // nv_cell_array

// ==== dv/nv_cell_shadow.sv ====
// Shadow copy of the byte cells used for expected read data
`timescale 1ns/10ps
module nv_cell_shadow;
  logic [7:0] mem [512];
  // Nine-bit linear index into 512 bytes
  task automatic put(input logic [8:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule // nv_cell_shadow

// ==== dv/test_nv_byte_access.sv ====
// Testbench for the byte access block
`timescale 1ns/10ps
`include "nv_access_consts.svh"
module test_nv_byte_access;
  import nv_access_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  io_req_t io_req = '0;
  logic io_strobe = 1'b0;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic write_aborted;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] seen;
  int n;
  always #10 clk = ~clk;
  nv_byte_access #(.WRITE_TIME_NS(600)) dut_u (
    .clk(clk), .reset(reset), .io_req(io_req), .io_strobe(io_strobe),
    .io_rdata(io_rdata), .cpu_stall(cpu_stall), .write_aborted(write_aborted));
  nv_cell_shadow shadow_u ();
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task put_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{we: 1'b1, addr: a, wdata: d};
    io_strobe <= 1'b1;
    @(posedge clk);
    io_strobe <= 1'b0;
    io_req.we <= 1'b0;
  endtask
  task get_reg(input logic [5:0] a);
    @(posedge clk);
    io_req <= '{we: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    @(negedge clk);
    seen = io_rdata;
  endtask
  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task expect_reg(input string what, input logic [5:0] a, input logic [7:0] exp);
    get_reg(a);
    check(what, exp, seen);
  endtask
  task check_stall(input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    repeat (8) begin
      @(negedge clk);
      if (cpu_stall === 1'b1) c = c + 8'h01;
    end
    check("stall cycles", exp, c);
  endtask
  task set_addr(input logic [8:0] a);
    put_reg(`NV_OFF_ADDR_HIGH, {7'h00, a[8]});
    put_reg(`NV_OFF_ADDR_LOW, a[7:0]);
  endtask
  task wait_idle();
    n = 0;
    do begin
      get_reg(`NV_OFF_CONTROL);
      n++;
    end while (seen[1] === 1'b1 && n < 60);
    check("control after write", 8'h00, seen);
  endtask
  task nv_write(input logic [8:0] a, input logic [7:0] d);
    set_addr(a);
    put_reg(`NV_OFF_DATA, d);
    put_reg(`NV_OFF_CONTROL, 8'h04);
    put_reg(`NV_OFF_CONTROL, 8'h02);
    check_stall(8'h02);
    expect_reg("control busy", `NV_OFF_CONTROL, 8'h02);
    wait_idle();
    check("write aborted", 8'h00, {7'h00, write_aborted});
    shadow_u.put(a, d);
  endtask
  task nv_read(input logic [8:0] a);
    wait_idle();
    set_addr(a);
    put_reg(`NV_OFF_DATA, 8'h00);
    put_reg(`NV_OFF_CONTROL, 8'h01);
    check_stall(8'h04);
    expect_reg("control after read", `NV_OFF_CONTROL, 8'h00);
    expect_reg("read data", `NV_OFF_DATA, shadow_u.mem[a]);
  endtask
  task stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    expect_reg("address high reset", `NV_OFF_ADDR_HIGH, 8'h00);
    expect_reg("address low reset", `NV_OFF_ADDR_LOW, 8'h00);
    expect_reg("control reset", `NV_OFF_CONTROL, 8'h00);
    put_reg(`NV_OFF_ADDR_HIGH, 8'hFF);
    expect_reg("address high unused", `NV_OFF_ADDR_HIGH, 8'h01);
    put_reg(`NV_OFF_CONTROL, 8'hF8);
    expect_reg("control reserved", `NV_OFF_CONTROL, 8'h00);
    $display("test register fields done");
    nv_write(9'h1A5, 8'hC3);
    nv_write(9'h0A5, 8'h3C);
    nv_read(9'h1A5);
    nv_read(9'h0A5);
    $display("test write and read done");
    set_addr(9'h0A5);
    put_reg(`NV_OFF_DATA, 8'h77);
    put_reg(`NV_OFF_CONTROL, 8'h02);
    check_stall(8'h00);
    expect_reg("unarmed strobe", `NV_OFF_CONTROL, 8'h00);
    put_reg(`NV_OFF_CONTROL, 8'h04);
    expect_reg("arm set", `NV_OFF_CONTROL, 8'h04);
    repeat (4) @(posedge clk);
    expect_reg("arm expired", `NV_OFF_CONTROL, 8'h00);
    put_reg(`NV_OFF_CONTROL, 8'h02);
    expect_reg("late strobe", `NV_OFF_CONTROL, 8'h00);
    nv_read(9'h0A5);
    $display("test arm timing done");
    set_addr(9'h0A5);
    put_reg(`NV_OFF_DATA, 8'h5A);
    put_reg(`NV_OFF_CONTROL, 8'h04);
    put_reg(`NV_OFF_CONTROL, 8'h02);
    put_reg(`NV_OFF_DATA, 8'hA5);
    wait_idle();
    check("write aborted", 8'h01, {7'h00, write_aborted});
    nv_read(9'h0A5);
    $display("test abort done");
    stop_test();
  end
endmodule // test_nv_byte_access
